// File: rtl/mrrb_pkg.sv
// Constants and carrier types for the measurement result readout bank.
// Assumes one 50 MHz clock shared by the bank, its register port and the engines.
//
// Summary of operation
// (R01) A high byte then its low byte read back to back come from one sample.
// (R02) First sensor pair at 0x2C/0x2D holds first thermistor or chip temperature.
// (R03) Sensor results are 14 bits: low byte 8 LSBs, high bits 5:0, 7:6 zero.
// (R04) Second thermistor at 0x2E/0x2F, third thermistor at 0x30/0x31.
// (R05) Coulomb counter is 16 bits: full high byte at 0x32, low byte at 0x33.
// (R06) Gain trim bits 4:3 sit at bits 3:2 of 0x50; other bits read zero.
// (R07) Gain trim bits 2:0 sit at bits 7:5 of 0x59; other bits read zero.
// (R08) Host computes gain as 365 uV plus trim code times 1 uV per count.
// (R09) Offset trim at 0x51 is signed two's complement in 1 mV steps.
// (R10) Trim registers are read-only; host writes change nothing. Here a write with no read in its cycle drops a pending pair capture.
// (R11) Host derives protection thresholds as raw codes using gain and offset trims.
// (R12) Host reads high byte first, then low byte, in one transaction.
`default_nettype none

package mrrb_pkg;

  // ===========================================================================
  // Register offsets.
  localparam logic [7:0] MRRB_OFS_THERMISTOR1_RESULT_HIGH  = 8'h2C;
  localparam logic [7:0] MRRB_OFS_THERMISTOR1_RESULT_LOW  = 8'h2D;
  localparam logic [7:0] MRRB_OFS_THERMISTOR2_RESULT_HIGH  = 8'h2E;
  localparam logic [7:0] MRRB_OFS_THERMISTOR2_RESULT_LOW  = 8'h2F;
  localparam logic [7:0] MRRB_OFS_THERMISTOR3_RESULT_HIGH  = 8'h30;
  localparam logic [7:0] MRRB_OFS_THERMISTOR3_RESULT_LOW  = 8'h31;
  localparam logic [7:0] MRRB_OFS_CHARGE_COUNT_HIGH   = 8'h32;
  localparam logic [7:0] MRRB_OFS_CHARGE_COUNT_LOW   = 8'h33;
  localparam logic [7:0] MRRB_OFS_GAIN_UP = 8'h50;
  localparam logic [7:0] MRRB_OFS_OFFSET  = 8'h51;
  localparam logic [7:0] MRRB_OFS_GAIN_LO = 8'h59;

  // ===========================================================================
  // Field layout and reset values.
  localparam int unsigned MRRB_SENS_W      = 14;
  localparam int unsigned MRRB_CC_W        = 16;
  localparam int unsigned MRRB_GAIN_W      = 5;
  localparam int unsigned MRRB_GAIN_UP_POS = 2;
  localparam int unsigned MRRB_GAIN_LO_POS = 5;
  localparam logic [13:0] MRRB_SENS_RST    = 14'h0000;
  localparam logic [15:0] MRRB_CC_RST      = 16'h0000;
  localparam logic [7:0]  MRRB_RDATA_IDLE  = 8'h00;

  // ===========================================================================
  // Carrier types.
  typedef struct packed {
    logic        valid;  // One-cycle strobe: a new result is present.
    logic [13:0] value;  // Sensor conversion result.
  } mrrb_sens_t;

  typedef struct packed {
    logic        valid;  // One-cycle strobe: a new count is present.
    logic [15:0] value;  // Coulomb counter result.
  } mrrb_cc_t;

  typedef struct packed {
    logic [4:0] gain;    // Unsigned gain trim code.
    logic [7:0] offset;  // Signed offset trim code.
  } mrrb_trim_t;

endpackage : mrrb_pkg

`default_nettype wire

// File: rtl/mrrb_bank.sv
// Read-only result register bank with coherent high/low byte pairs.
// Assumes result strobes and trim values come from logic on MCLK, and a
// register master that obeys one-cycle strobes with read data a cycle later.
//
// Added by the designer: the plain strobed port.
`default_nettype none
`timescale 1ns/1ps

module mrrb_bank
  import mrrb_pkg::*;
(
  input  wire logic       MCLK,          // 50 MHz clock.
  input  wire logic       NRST,          // Asynchronous reset, active low.
  input  wire logic [7:0] ADDR,          // Register address.
  input  wire logic [7:0] WDATA,         // Write data, ignored by this bank.
  input  wire logic       WR_STB,        // Write strobe.
  input  wire logic       RD_STB,        // Read strobe.
  output logic      [7:0] RDATA,         // Read data, valid the cycle after a read.
  input  wire logic       TEMP_SRC_SEL,  // 1: first pair shows chip temperature.
  input  wire mrrb_sens_t TS1_IN,        // First thermistor result.
  input  wire mrrb_sens_t DIE_IN,        // Chip temperature result.
  input  wire mrrb_sens_t TS2_IN,        // Second thermistor result.
  input  wire mrrb_sens_t TS3_IN,        // Third thermistor result.
  input  wire mrrb_cc_t   CC_IN,         // Coulomb counter result.
  input  wire mrrb_trim_t TRIM           // Production trim values.
);

  // ===========================================================================
  // Result holding registers and pair shadow.
  logic [13:0] ts1_r;
  logic [13:0] ts1_nxt;
  logic [13:0] ts2_r;
  logic [13:0] ts2_nxt;
  logic [13:0] ts3_r;
  logic [13:0] ts3_nxt;
  logic [15:0] cc_r;
  logic [15:0] cc_nxt;
  logic [7:0]  shadow_r;
  logic [7:0]  shadow_nxt;
  logic [7:0]  shadow_addr_r;
  logic [7:0]  shadow_addr_nxt;
  logic        shadow_vld_r;
  logic        shadow_vld_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;

  // Returns the 14-bit sensor high byte with the two top bits forced to zero.
  function automatic logic [7:0] sens_hi(input logic [13:0] v);
    sens_hi = {2'b00, v[13:8]};
  endfunction : sens_hi

  // Returns the live value at an address; unmapped addresses read as zero.
  function automatic logic [7:0] live_read(input logic [7:0] a,
                                           input logic [13:0] t1,
                                           input logic [13:0] t2,
                                           input logic [13:0] t3,
                                           input logic [15:0] c,
                                           input mrrb_trim_t tr);
    live_read = MRRB_RDATA_IDLE;
    unique case (a)
      MRRB_OFS_THERMISTOR1_RESULT_HIGH:  live_read = sens_hi(t1);  // R02
      MRRB_OFS_THERMISTOR1_RESULT_LOW:  live_read = t1[7:0];      // R03
      MRRB_OFS_THERMISTOR2_RESULT_HIGH:  live_read = sens_hi(t2);  // R04
      MRRB_OFS_THERMISTOR2_RESULT_LOW:  live_read = t2[7:0];
      MRRB_OFS_THERMISTOR3_RESULT_HIGH:  live_read = sens_hi(t3);
      MRRB_OFS_THERMISTOR3_RESULT_LOW:  live_read = t3[7:0];
      MRRB_OFS_CHARGE_COUNT_HIGH:   live_read = c[15:8];      // R05
      MRRB_OFS_CHARGE_COUNT_LOW:   live_read = c[7:0];
      MRRB_OFS_GAIN_UP: live_read = 8'(tr.gain[4:3]) << MRRB_GAIN_UP_POS;  // R06
      MRRB_OFS_GAIN_LO: live_read = 8'(tr.gain[2:0]) << MRRB_GAIN_LO_POS;  // R07
      MRRB_OFS_OFFSET:  live_read = tr.offset;    // R09
      default:          live_read = MRRB_RDATA_IDLE;
    endcase
  endfunction : live_read

  // Tells whether an address is the high byte of a result pair.
  function automatic logic is_pair_hi(input logic [7:0] a);
    is_pair_hi = (a == MRRB_OFS_THERMISTOR1_RESULT_HIGH) || (a == MRRB_OFS_THERMISTOR2_RESULT_HIGH) ||
                 (a == MRRB_OFS_THERMISTOR3_RESULT_HIGH) || (a == MRRB_OFS_CHARGE_COUNT_HIGH);
  endfunction : is_pair_hi

  // ===========================================================================
  // Result capture: each engine strobe loads its holding register; TEMP_SRC_SEL picks whether TS1_IN or DIE_IN loads the first pair.
  always_comb begin
    ts1_nxt = ts1_r;
    ts2_nxt = ts2_r;
    ts3_nxt = ts3_r;
    cc_nxt  = cc_r;
    if (TEMP_SRC_SEL) begin
      if (DIE_IN.valid) begin
        ts1_nxt = DIE_IN.value;  // R02
      end
    end else if (TS1_IN.valid) begin
      ts1_nxt = TS1_IN.value;    // R02
    end
    if (TS2_IN.valid) begin
      ts2_nxt = TS2_IN.value;    // R04
    end
    if (TS3_IN.valid) begin
      ts3_nxt = TS3_IN.value;    // R04
    end
    if (CC_IN.valid) begin
      cc_nxt = CC_IN.value;      // R05
    end
  end

  // Registers the results.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ts1_r <= MRRB_SENS_RST;
      ts2_r <= MRRB_SENS_RST;
      ts3_r <= MRRB_SENS_RST;
      cc_r  <= MRRB_CC_RST;
    end else begin
      ts1_r <= ts1_nxt;
      ts2_r <= ts2_nxt;
      ts3_r <= ts3_nxt;
      cc_r  <= cc_nxt;
    end
  end

  // ===========================================================================
  // Register port: a high-byte read freezes the partner low byte, and the
  // very next access, if it reads that low byte, returns the frozen copy.
  // Any other access drops the copy, so a stale byte is never served later.
  always_comb begin
    logic [7:0] lo_addr;
    lo_addr         = ADDR + 8'h01;
    shadow_nxt      = shadow_r;
    shadow_addr_nxt = shadow_addr_r;
    shadow_vld_nxt  = shadow_vld_r;
    rdata_nxt       = MRRB_RDATA_IDLE;
    if (RD_STB) begin
      if (shadow_vld_r && (ADDR == shadow_addr_r)) begin
        rdata_nxt = shadow_r;                                  // R01
      end else begin
        rdata_nxt = live_read(ADDR, ts1_r, ts2_r, ts3_r, cc_r, TRIM);
      end
      shadow_vld_nxt = is_pair_hi(ADDR);                       // R01
      if (is_pair_hi(ADDR)) begin
        shadow_nxt      = live_read(lo_addr, ts1_r, ts2_r, ts3_r, cc_r, TRIM);
        shadow_addr_nxt = lo_addr;
      end
    end else if (WR_STB) begin
      shadow_vld_nxt = 1'b0;  // R10
    end
  end

  // Registers the port state.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      shadow_r      <= MRRB_RDATA_IDLE;
      shadow_addr_r <= MRRB_RDATA_IDLE;
      shadow_vld_r  <= 1'b0;
      rdata_r       <= MRRB_RDATA_IDLE;
    end else begin
      shadow_r      <= shadow_nxt;
      shadow_addr_r <= shadow_addr_nxt;
      shadow_vld_r  <= shadow_vld_nxt;
      rdata_r       <= rdata_nxt;
    end
  end

  assign RDATA = rdata_r;

  // ===========================================================================
  // Assertions and covers.
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);

  AST_PAIR_COHERENT: assert property ( // R01
    (RD_STB && ADDR == MRRB_OFS_CHARGE_COUNT_HIGH) ##1 (RD_STB && ADDR == MRRB_OFS_CHARGE_COUNT_LOW)
    |=> RDATA == $past(cc_r[7:0], 2))
    else $error("Coulomb low byte not from the same sample as high byte.");

  AST_TS1_HIGH: assert property ( // R02
    (RD_STB && ADDR == MRRB_OFS_THERMISTOR1_RESULT_HIGH) |=> RDATA == {2'b00, $past(ts1_r[13:8])})
    else $error("First sensor high byte wrong.");

  AST_TS2_TOP_ZERO: assert property ( // R03
    (RD_STB && ADDR == MRRB_OFS_THERMISTOR2_RESULT_HIGH) |=> RDATA[7:6] == 2'b00)
    else $error("Sensor high byte top bits not zero.");

  AST_TS3_HIGH: assert property ( // R04
    (RD_STB && ADDR == MRRB_OFS_THERMISTOR3_RESULT_HIGH) |=> RDATA[5:0] == $past(ts3_r[13:8]))
    else $error("Third sensor high byte wrong.");

  AST_CC_HIGH: assert property ( // R05
    (RD_STB && ADDR == MRRB_OFS_CHARGE_COUNT_HIGH) |=> RDATA == $past(cc_r[15:8]))
    else $error("Coulomb high byte wrong.");

  AST_GAIN_UPPER: assert property ( // R06
    (RD_STB && ADDR == MRRB_OFS_GAIN_UP)
    |=> RDATA == {4'h0, $past(TRIM.gain[4:3]), 2'b00})
    else $error("Gain upper field misplaced.");

  AST_GAIN_LOWER: assert property ( // R07
    (RD_STB && ADDR == MRRB_OFS_GAIN_LO)
    |=> RDATA == {$past(TRIM.gain[2:0]), 5'h00})
    else $error("Gain lower field misplaced.");

  AST_OFFSET: assert property ( // R09
    (RD_STB && ADDR == MRRB_OFS_OFFSET) |=> RDATA == $past(TRIM.offset))
    else $error("Offset trim read wrong.");

  AST_TRIM_WRITE_IGNORED: assert property ( // R10
    (WR_STB && ADDR == MRRB_OFS_OFFSET) ##1 (RD_STB && ADDR == MRRB_OFS_OFFSET)
    |=> RDATA == $past(TRIM.offset))
    else $error("Write altered the offset trim.");

  AST_RDATA_IDLE: assert property (
    !RD_STB |=> RDATA == MRRB_RDATA_IDLE)
    else $error("Read data present without a read.");

  // The remaining pair checks cover the three sensor pairs the same way as the
  // coulomb pair: the low byte of a back-to-back read comes from the sample
  // that was live when the high byte was taken, whatever loads in between.
  AST_TS1_PAIR: assert property ( // R01
    (RD_STB && ADDR == MRRB_OFS_THERMISTOR1_RESULT_HIGH) ##1 (RD_STB && ADDR == MRRB_OFS_THERMISTOR1_RESULT_LOW)
    |=> RDATA == $past(ts1_r[7:0], 2))
    else $error("First sensor low byte not from the same sample as high byte.");

  AST_TS2_PAIR: assert property ( // R01
    (RD_STB && ADDR == MRRB_OFS_THERMISTOR2_RESULT_HIGH) ##1 (RD_STB && ADDR == MRRB_OFS_THERMISTOR2_RESULT_LOW)
    |=> RDATA == $past(ts2_r[7:0], 2))
    else $error("Second sensor low byte not from the same sample as high byte.");

  AST_TS3_PAIR: assert property ( // R01
    (RD_STB && ADDR == MRRB_OFS_THERMISTOR3_RESULT_HIGH) ##1 (RD_STB && ADDR == MRRB_OFS_THERMISTOR3_RESULT_LOW)
    |=> RDATA == $past(ts3_r[7:0], 2))
    else $error("Third sensor low byte not from the same sample as high byte.");

  // A low byte read with no capture pending must show the live value.
  AST_CC_LOW_LIVE: assert property ( // R05
    (RD_STB && ADDR == MRRB_OFS_CHARGE_COUNT_LOW && !shadow_vld_r)
    |=> RDATA == $past(cc_r[7:0]))
    else $error("Coulomb low byte not live without a pending capture.");

  // A write between the two reads drops the capture.
  AST_WRITE_DROPS_CAPTURE: assert property ( // R10
    (WR_STB && !RD_STB) |=> !shadow_vld_r)
    else $error("Write left a pair capture pending.");

  AST_TS2_HIGH: assert property ( // R04
    (RD_STB && ADDR == MRRB_OFS_THERMISTOR2_RESULT_HIGH) |=> RDATA == {2'b00, $past(ts2_r[13:8])})
    else $error("Second sensor high byte wrong.");

  AST_TS1_TOP_ZERO: assert property ( // R03
    (RD_STB && ADDR == MRRB_OFS_THERMISTOR1_RESULT_HIGH) |=> RDATA[7:6] == 2'b00)
    else $error("First sensor high byte top bits not zero.");

  AST_TS3_TOP_ZERO: assert property ( // R03
    (RD_STB && ADDR == MRRB_OFS_THERMISTOR3_RESULT_HIGH) |=> RDATA[7:6] == 2'b00)
    else $error("Third sensor high byte top bits not zero.");

  AST_GAIN_UP_SPARE: assert property ( // R06
    (RD_STB && ADDR == MRRB_OFS_GAIN_UP) |=> (RDATA[7:4] == 4'h0) && (RDATA[1:0] == 2'b00))
    else $error("Gain upper register spare bits not zero.");

  AST_GAIN_LO_SPARE: assert property ( // R07
    (RD_STB && ADDR == MRRB_OFS_GAIN_LO) |=> RDATA[4:0] == 5'h00)
    else $error("Gain lower register spare bits not zero.");

  // Addresses above the last trim register are unmapped and read as zero.
  AST_UNMAPPED_ZERO: assert property (
    (RD_STB && ADDR > MRRB_OFS_GAIN_LO) |=> RDATA == MRRB_RDATA_IDLE)
    else $error("Unmapped address returned data.");

  // Result loading: each strobe lands in its holding register next cycle; TS1_IN and DIE_IN only when TEMP_SRC_SEL selects them.
  AST_TS1_LOAD: assert property ( // R02
    (!TEMP_SRC_SEL && TS1_IN.valid) |=> ts1_r == $past(TS1_IN.value))
    else $error("First thermistor result not loaded.");

  AST_DIE_LOAD: assert property ( // R02
    (TEMP_SRC_SEL && DIE_IN.valid) |=> ts1_r == $past(DIE_IN.value))
    else $error("Chip temperature result not loaded.");

  AST_DIE_SOURCE_ONLY: assert property ( // R02
    (TEMP_SRC_SEL && !DIE_IN.valid) |=> $stable(ts1_r))
    else $error("First pair changed without a chip temperature strobe.");

  AST_TS2_LOAD: assert property ( // R04
    TS2_IN.valid |=> ts2_r == $past(TS2_IN.value))
    else $error("Second thermistor result not loaded.");

  AST_TS3_LOAD: assert property ( // R04
    TS3_IN.valid |=> ts3_r == $past(TS3_IN.value))
    else $error("Third thermistor result not loaded.");

  AST_CC_LOAD: assert property ( // R05
    CC_IN.valid |=> cc_r == $past(CC_IN.value))
    else $error("Coulomb counter result not loaded.");

  // Covers for the main scenarios.
  COV_LIVE_LOW: cover property (RD_STB && ADDR == MRRB_OFS_CHARGE_COUNT_LOW && !shadow_vld_r);
  COV_PAIR_WITH_UPDATE: cover property (
    (RD_STB && ADDR == MRRB_OFS_THERMISTOR1_RESULT_HIGH) ##1 (RD_STB && TS1_IN.valid && !TEMP_SRC_SEL));
  COV_DIE_SOURCE: cover property (TEMP_SRC_SEL && DIE_IN.valid);
  COV_CC_PAIR: cover property (
    (RD_STB && ADDR == MRRB_OFS_CHARGE_COUNT_HIGH) ##1 (RD_STB && ADDR == MRRB_OFS_CHARGE_COUNT_LOW));
  COV_TRIM_WRITE: cover property (WR_STB && ADDR == MRRB_OFS_GAIN_UP);

endmodule : mrrb_bank

`default_nettype wire

// File: testbench/mrrb_host.sv
// Host model that reads and writes the result bank registers.
// Assumes read data stand in the one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none

module mrrb_host (
  input  wire logic       mclk,    // Bank clock.
  output logic      [7:0] addr,    // Register address.
  output logic      [7:0] wdata,   // Write data.
  output logic            wr_stb,  // Write strobe.
  output logic            rd_stb,  // Read strobe.
  input  wire logic [7:0] rdata    // Read data.
);
  // ==========================================================================
  // Idle bus levels at time zero.
  initial begin
    addr   = 8'h00;
    wdata  = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  // Single read; data taken in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask : rd

  // High byte then low byte back to back, as one transaction.
  task automatic rd_pair(input logic [7:0] a, output logic [7:0] dh, output logic [7:0] dl);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    addr   <= a + 8'h01;
    @(negedge mclk);
    dh = rdata;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    dl = rdata;
  endtask : rd_pair

  // Single write cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    wdata  <= 8'h00;
  endtask : wr

endmodule : mrrb_host

`default_nettype wire

// File: testbench/measurement_result_readout_bank_tb_top.sv
// Self-checking bench for the result bank, driven through the host model.
// Assumes the bank answers reads one cycle late and ignores write data.
`timescale 1ns/1ps
`default_nettype none

module measurement_result_readout_bank_tb_top
  import mrrb_pkg::*;
();
  typedef struct packed {logic [7:0] a; logic [7:0] x;} mrrb_row_t;
  logic       mclk, nrst, sel, wr_stb, rd_stb;
  logic [7:0] addr, wdata, rdata, d, e;
  mrrb_sens_t ts1, die, ts2, ts3;
  mrrb_cc_t   cc;
  mrrb_trim_t trim;
  int         err_count = 0;
  int         n_tests = 0;
  int         cycles = 0;
  mrrb_row_t  rows [13] = '{'{8'h2C, 8'h3A}, '{8'h2D, 8'h5C}, '{8'h2E, 8'h12},
    '{8'h2F, 8'h34}, '{8'h30, 8'h3F}, '{8'h31, 8'hFF}, '{8'h32, 8'hBE}, '{8'h33, 8'hEF},
    '{8'h50, 8'h08}, '{8'h51, 8'h80}, '{8'h59, 8'hC0}, '{8'h34, 8'h00}, '{8'h52, 8'h00}};

  mrrb_bank u_mrrb_bank (.MCLK(mclk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .TEMP_SRC_SEL(sel), .TS1_IN(ts1),
    .DIE_IN(die), .TS2_IN(ts2), .TS3_IN(ts3), .CC_IN(cc), .TRIM(trim));
  mrrb_host u_mrrb_host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata));

  // ==========================================================================
  // Clock, timeout and shared tasks.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Cuts a hung run short.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Loads one new sample on every result input for one cycle.
  task automatic pulse(input logic [13:0] t1, input logic [13:0] dv, input logic [15:0] c);
    @(posedge mclk);
    ts1 <= {1'b1, t1};
    die <= {1'b1, dv};
    ts2 <= {1'b1, 14'h1234};
    ts3 <= {1'b1, 14'h3FFF};
    cc  <= {1'b1, c};
    @(posedge mclk);
    ts1.valid <= 1'b0;
    die.valid <= 1'b0;
    ts2.valid <= 1'b0;
    ts3.valid <= 1'b0;
    cc.valid  <= 1'b0;
  endtask : pulse

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // Main sequence.
  initial begin
    nrst = 1'b0;
    sel  = 1'b0;
    ts1  = '0;
    die  = '0;
    ts2  = '0;
    ts3  = '0;
    cc   = '0;
    trim = {5'h16, 8'h80};
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    // Result registers are clear after reset.
    for (int i = 0; i < 8; i++) begin
      u_mrrb_host.rd(8'h2C + 8'(i), d);
      check("reset", d, 8'h00);
    end
    // Chip temperature is ignored while the thermistor is selected.
    pulse(14'h3A5C, 14'h0155, 16'hBEEF);
    foreach (rows[i]) begin
      u_mrrb_host.rd(rows[i].a, d);
      check("table", d, rows[i].x);
    end
    // Source select moves the first pair to chip temperature.
    @(posedge mclk);
    sel <= 1'b1;
    pulse(14'h2222, 14'h0155, 16'hBEEF);
    u_mrrb_host.rd_pair(8'h2C, d, e);
    check("die lo", e, 8'h55);
    check("die hi", d, 8'h01);
    // A new count between the two reads of a pair must not split it.
    fork
      u_mrrb_host.rd_pair(8'h32, d, e);
      begin
        pulse(14'h2222, 14'h0155, 16'h1357);
      end
    join
    check("pair hi", d, 8'hBE);
    check("pair lo", e, 8'hEF);
    u_mrrb_host.rd(8'h33, d);
    check("live lo", d, 8'h57);
    // A write between high and low drops the capture; trim writes leave the trim values unchanged.
    u_mrrb_host.rd(8'h32, d);
    check("hi", d, 8'h13);
    pulse(14'h2222, 14'h0155, 16'h2468);
    u_mrrb_host.wr(8'h51, 8'h00);
    u_mrrb_host.rd(8'h33, d);
    check("drop lo", d, 8'h68);
    u_mrrb_host.wr(8'h50, 8'hFF);
    u_mrrb_host.wr(8'h59, 8'h00);
    u_mrrb_host.rd(8'h51, d);
    check("offset", d, 8'h80);
    u_mrrb_host.rd(8'h50, d);
    u_mrrb_host.rd(8'h59, e);
    check("gain up", d, 8'h08);
    check("gain", {3'h0, d[3:2], e[7:5]}, 8'h16);
    print_verdict();
  end

endmodule : measurement_result_readout_bank_tb_top

`default_nettype wire
